/* design/qds_pkg.sv */
package qds_pkg;

    // ==========================================================
    // Word layout
    // ==========================================================
    localparam int WORD_BITS    = 16;
    localparam int CODE_BITS    = 12;
    localparam int ADDR_HI_POS  = 15;
    localparam int ADDR_LO_POS  = 14;
    localparam int SLEEP_POS    = 13;
    localparam int FAST_POS     = 12;
    localparam int CHANNELS     = 4;
    localparam int FIFO_DEPTH   = 8;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [11:0] CODE_RESET = 12'h000;
    localparam logic [4:0]  CNT_RESET  = 5'h00;
    localparam logic [3:0]  SYNC_RESET = 4'hF;

endpackage : qds_pkg

/* design/qds_fifo.sv */
`timescale 1ns/10ps
`default_nettype none
module qds_fifo
    import qds_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             clock,
    input  wire logic             rst_b,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               rd;
        logic [AW-1:0]               wr;
        logic [AW:0]                 cnt;
    } qds_fifo_t;

    qds_fifo_t st;
    qds_fifo_t next_st;
    logic      push;
    logic      pop;

    // ==========================================================
    // Pointer and storage update
    // ==========================================================
    always_comb begin
        next_st = st;
        push = in_valid && (st.cnt != DEPTH[AW:0]);
        pop  = out_ready && (st.cnt != '0);
        if (push) begin
            next_st.mem[st.wr] = in_data;
            next_st.wr = st.wr + 1'b1;
        end
        if (pop) begin
            next_st.rd = st.rd + 1'b1;
        end
        next_st.cnt = st.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Full and empty come from the count, so both are exact
    assign in_ready  = (st.cnt != DEPTH[AW:0]);
    assign out_valid = (st.cnt != '0);
    assign out_data  = st.mem[st.rd];

endmodule : qds_fifo
`default_nettype wire

/* design/qds_dac_if.sv */
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Frame sync falling starts frame; bits shift MSB first on clock falls.
// - Word goes to addressed latch after sixteen bits or early frame sync rise.
// - Update on first clock rise after last bit, or on frame sync rise.
// - Reset clears all channel codes and control bits to zero.
// - Each channel code is an unsigned twelve-bit value.
// - Separate chip selects let several devices share sync, clock and data.
// - Bits 15:14 address, 13 sleep, 12 fast, 11:0 code.
// - Address 00 selects A, 01 B, 10 C, 11 D.
// - Outputs follow latched codes only while load strobe is low.
// - Low power-down input sleeps all channels, overriding sleep bits.
module qds_dac_if
    import qds_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  rst_b,
    input  wire logic                  chip_select_n,
    input  wire logic                  frame_sync_n,
    input  wire logic                  serial_clock,
    input  wire logic                  serial_data,
    input  wire logic                  load_strobe_n,
    input  wire logic                  power_down_n,
    output logic [CHANNELS*12-1:0]     dac_code,
    output logic [CHANNELS-1:0]        channel_sleep,
    output logic [CHANNELS-1:0]        fast_settle,
    output logic                       word_busy
);
    typedef struct packed {
        logic [3:0][2:0]                  sync;
        logic [3:0]                       agreed;
        logic [WORD_BITS-1:0]             shift;
        logic [4:0]                       count;
        logic                             active;
        logic                             done;
        logic [CHANNELS-1:0][CODE_BITS-1:0] held;
        logic [CHANNELS-1:0]              held_sleep;
        logic [CHANNELS-1:0]              held_fast;
        logic [CHANNELS*12-1:0]           code_out;
        logic [CHANNELS-1:0]              sleep_out;
        logic [CHANNELS-1:0]              fast_out;
        logic                             busy_out;
    } qds_state_t;

    qds_state_t st;
    qds_state_t next_st;

    // Agreed level of a three-stage synchroniser: stages 2 and 3 agree
    function automatic logic settled(input logic [2:0] s, input logic prev);
        return (s[1] == s[2]) ? s[1] : prev;
    endfunction

    logic cs_q, fs_q, sck_q, din_q;
    logic cs_p, fs_p, sck_p;
    logic fs_fall, fs_rise, sck_fall, sck_rise;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [WORD_BITS-1:0] fifo_in_data;
    logic fifo_out_valid;
    logic [WORD_BITS-1:0] fifo_out_data;
    logic [WORD_BITS-1:0] word;
    logic [1:0] ch;
    logic last_edge;

    // Agreed pin levels of the previous cycle; an edge is a change of agreement
    logic [3:0] next_agreed;

    // ==========================================================
    // Edge finding on the sampled pins
    // ==========================================================
    always_comb begin
        cs_p  = st.agreed[0];
        fs_p  = st.agreed[1];
        sck_p = st.agreed[2];
        cs_q  = settled(st.sync[0], cs_p);
        fs_q  = settled(st.sync[1], fs_p);
        sck_q = settled(st.sync[2], sck_p);
        din_q = st.sync[3][2];
        next_agreed = {st.agreed[3], sck_q, fs_q, cs_q};
        fs_fall  = fs_p && !fs_q && !cs_q;
        fs_rise  = !fs_p && fs_q;
        sck_fall = sck_p && !sck_q;
        sck_rise = !sck_p && sck_q;
    end

    // ==========================================================
    // Frame capture and latch control
    // ==========================================================
    always_comb begin
        next_st = st;
        fifo_in_valid = 1'b0;
        fifo_in_data  = st.shift;
        last_edge     = 1'b0;
        next_st.sync[0] = {st.sync[0][1:0], chip_select_n};
        next_st.sync[1] = {st.sync[1][1:0], frame_sync_n};
        next_st.sync[2] = {st.sync[2][1:0], serial_clock};
        next_st.sync[3] = {st.sync[3][1:0], serial_data};
        next_st.agreed  = next_agreed;
        // Restart count on every new frame
        if (fs_fall) begin
            next_st.active = 1'b1;
            next_st.done   = 1'b0;
            next_st.count  = CNT_RESET;
        end else if (st.active && cs_q) begin
            next_st.active = 1'b0;
        end else if (st.active && !st.done && sck_fall) begin
            next_st.shift = {st.shift[WORD_BITS-2:0], din_q};
            next_st.count = st.count + 5'h01;
            if (st.count == 5'(WORD_BITS - 1)) begin
                next_st.done = 1'b1;
            end
        end else if (st.active && st.done && sck_rise) begin
            last_edge = 1'b1;
        end else if (st.active && fs_rise) begin
            last_edge = 1'b1;
        end
        // Word leaves only when the FIFO has room; otherwise it waits for another closing edge
        if (last_edge && fifo_in_ready) begin
            fifo_in_valid = 1'b1;
            next_st.active = 1'b0;
            if (!st.done) begin
                // Short frame: align the received bits as a full word
                fifo_in_data = st.shift << (5'(WORD_BITS) - st.count);
            end
        end
        // Drain the FIFO into the addressed latch
        word = fifo_out_data;
        ch   = word[ADDR_HI_POS:ADDR_LO_POS];
        if (fifo_out_valid) begin
            next_st.held[ch]       = word[CODE_BITS-1:0];
            next_st.held_sleep[ch] = word[SLEEP_POS];
            next_st.held_fast[ch]  = word[FAST_POS];
        end
        // Outputs follow held values only while the load strobe is low
        if (!load_strobe_n) begin
            next_st.code_out = st.held;
            next_st.fast_out = st.held_fast;
            next_st.sleep_out = st.held_sleep;
        end
        if (!power_down_n) begin
            next_st.sleep_out = '1;
        end
        next_st.busy_out = next_st.active;
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
            st.sync <= {4{3'b111}};
            st.agreed <= SYNC_RESET;
        end else begin
            st <= next_st;
        end
    end

    qds_fifo #(
        .WIDTH (WORD_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .rst_b     (rst_b),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (fifo_out_valid),
        .out_ready (1'b1),
        .out_data  (fifo_out_data)
    );

    assign dac_code      = st.code_out;
    assign channel_sleep = st.sleep_out;
    assign fast_settle   = st.fast_out;
    assign word_busy     = st.busy_out;

    // ==========================================================
    // Checks
    // ==========================================================
    chk_pd_override: assert property (@(posedge clock) disable iff (!rst_b)
        !power_down_n |=> channel_sleep == '1)
        else $error("power-down input did not sleep all channels");
    chk_strobe_hold: assert property (@(posedge clock) disable iff (!rst_b)
        load_strobe_n && $past(load_strobe_n) && power_down_n |-> $stable(dac_code))
        else $error("outputs moved while load strobe high");
    chk_frame_start: assert property (@(posedge clock) disable iff (!rst_b)
        fs_fall |=> st.active && st.count == 5'h00)
        else $error("frame start did not reset count");
    chk_word_push: assert property (@(posedge clock) disable iff (!rst_b)
        fifo_in_valid |=> !st.active)
        else $error("capture stayed active after word latch");
    chk_latch_write: assert property (@(posedge clock) disable iff (!rst_b)
        fifo_out_valid |=> st.held[$past(ch)] == $past(fifo_out_data[11:0]))
        else $error("latch not written with word code");
    chk_idle_ignore: assert property (@(posedge clock) disable iff (!rst_b)
        !st.active && !fs_fall |=> $stable(st.shift))
        else $error("shift register moved outside a frame");
    chk_count_cap: assert property (@(posedge clock) disable iff (!rst_b)
        st.count <= 5'h10)
        else $error("bit count passed sixteen");
    chk_cs_block: assert property (@(posedge clock) disable iff (!rst_b)
        cs_q && !st.active |=> !st.active)
        else $error("frame accepted while deselected");
    chk_shift_order: assert property (@(posedge clock) disable iff (!rst_b)
        st.active && !st.done && sck_fall && !fs_fall && !cs_q
        |=> st.shift[0] == $past(din_q) && st.count == $past(st.count) + 5'h01)
        else $error("bit not shifted in on serial clock fall");
    chk_lsb_update: assert property (@(posedge clock) disable iff (!rst_b)
        st.active && st.done && sck_rise && !fs_fall && !cs_q && fifo_in_ready
        |-> fifo_in_valid)
        else $error("word not pushed on clock rise after last bit");
    chk_short_latch: assert property (@(posedge clock) disable iff (!rst_b)
        st.active && !st.done && fs_rise && !cs_q && !sck_fall && fifo_in_ready
        |-> fifo_in_valid)
        else $error("cut frame was not latched");
    chk_code_load: assert property (@(posedge clock) disable iff (!rst_b)
        !load_strobe_n |=> dac_code == $past(st.held))
        else $error("outputs did not follow held codes with load strobe low");

endmodule : qds_dac_if
`default_nettype wire

/* bench/qds_host.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Host serial port model, link clock 64 ns, parked high outside frames
// ==========================================================
module qds_host (
    output logic chip_select_n,
    output logic frame_sync_n,
    output logic serial_clock,
    output logic serial_data
);
    // Idle state: select held low for three-wire use
    initial begin
        chip_select_n = 1'b0;
        frame_sync_n  = 1'b1;
        serial_clock  = 1'b1;
        serial_data   = 1'b0;
    end

    // Sends n bits MSB first, then extra stray clocks before sync rises
    task automatic send(input logic [15:0] w, input int n, input int extra, input logic cs_n);
        chip_select_n = cs_n;
        #20 frame_sync_n = 1'b0;
        #20;
        for (int i = 0; i < n + extra; i++) begin
            serial_data = (i < n) ? w[15 - i] : ~serial_data;
            #32 serial_clock = 1'b0;
            #32 serial_clock = 1'b1;
        end
        #20 frame_sync_n = 1'b1;
        // Released data line toggles so a stale bit cannot pass for a good one
        serial_data = ~serial_data;
        #20 chip_select_n = 1'b0;
    endtask : send
endmodule : qds_host
`default_nettype wire

/* bench/qds_dac_if_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define QDS_CHECK(got, exp) begin compares++; if ((got) !== (exp)) begin n_errors++; \
    $display("wrong value at %0t got %h expected %h", $time, got, exp); end end
module qds_dac_if_tb;
    import qds_pkg::*;
    logic                   clock, rst_b, load_strobe_n, power_down_n;
    logic                   cs_n, fs_n, sck, sdi, word_busy;
    logic [CHANNELS*12-1:0] dac_code, shown;
    logic [CHANNELS-1:0]    channel_sleep, fast_settle, exp_sleep, exp_fast;
    logic [11:0]            exp_code [CHANNELS];
    logic [15:0]            lfsr;
    int                     n_errors, compares;

    qds_host host_i (.chip_select_n(cs_n), .frame_sync_n(fs_n), .serial_clock(sck),
        .serial_data(sdi));
    qds_dac_if qds_dac_if_i (.clock(clock), .rst_b(rst_b), .chip_select_n(cs_n),
        .frame_sync_n(fs_n), .serial_clock(sck), .serial_data(sdi),
        .load_strobe_n(load_strobe_n), .power_down_n(power_down_n), .dac_code(dac_code),
        .channel_sleep(channel_sleep), .fast_settle(fast_settle), .word_busy(word_busy));

    // ==========================================================
    // Expectation helpers
    // ==========================================================
    function automatic logic [15:0] lfsr_step(input logic [15:0] s);
        return {1'b0, s[15:1]} ^ (s[0] ? 16'hB400 : 16'h0000);
    endfunction : lfsr_step

    function automatic logic [CHANNELS*12-1:0] pack_code();
        logic [CHANNELS*12-1:0] p;
        for (int c = 0; c < CHANNELS; c++) p[c*12 +: 12] = exp_code[c];
        return p;
    endfunction : pack_code

    task automatic check_all();
        `QDS_CHECK(dac_code, pack_code())
        `QDS_CHECK(channel_sleep, exp_sleep | {CHANNELS{~power_down_n}})
        `QDS_CHECK(fast_settle, exp_fast)
    endtask : check_all

    // Short frames keep only the bits received, low bits read as zero
    task automatic frame(input logic [15:0] w, input int n, input int extra, input logic cs);
        logic [15:0] m;
        m = w & ~(16'hFFFF >> n);
        // Busy is looked at well inside the frame, before the shortest one ends
        fork
            host_i.send(w, n, extra, cs);
            begin
                repeat (60) @(posedge clock);
                `QDS_CHECK(word_busy, ~cs)
            end
        join
        if (cs == 1'b0) begin
            exp_code[m[15:14]]  = m[11:0];
            exp_sleep[m[15:14]] = m[13];
            exp_fast[m[15:14]]  = m[12];
        end
        repeat (12) @(posedge clock);
        `QDS_CHECK(word_busy, 1'b0)
    endtask : frame

    task automatic print_verdict();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict

    // ==========================================================
    // Clock, watchdog and main sequence
    // ==========================================================
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // Cuts a hung run short and counts it as a mismatch
    initial begin
        #200000;
        n_errors++;
        print_verdict();
    end

    initial begin
        rst_b = 1'b0; load_strobe_n = 1'b0; power_down_n = 1'b1;
        lfsr = 16'd65231; n_errors = 0; compares = 0;
        exp_sleep = '0; exp_fast = '0;
        for (int c = 0; c < CHANNELS; c++) exp_code[c] = CODE_RESET;
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        repeat (8) @(posedge clock);
        check_all();
        // Random words cycling through every address
        for (int k = 0; k < 8; k++) begin
            lfsr = lfsr_step(lfsr);
            frame({2'(k), lfsr[13:0]}, 16, 0, 1'b0);
            check_all();
        end
        // Code extremes, then stray clocks after the word must not shift
        frame(16'h3FFF, 16, 0, 1'b0);
        frame(16'hC000, 16, 0, 1'b0);
        frame(16'h6ABC, 16, 5, 1'b0);
        check_all();
        frame(16'hA5A5, 10, 0, 1'b0);
        check_all();
        // Deselected device ignores the frame
        frame(lfsr_step(lfsr), 16, 0, 1'b1);
        check_all();
        // Held codes stay hidden while the load strobe is high
        @(posedge clock);
        load_strobe_n <= 1'b1;
        shown = pack_code();
        frame(16'h9123, 16, 0, 1'b0);
        `QDS_CHECK(dac_code, shown)
        @(posedge clock);
        load_strobe_n <= 1'b0;
        repeat (8) @(posedge clock);
        check_all();
        // Hardware sleep overrides every channel bit
        power_down_n <= 1'b0;
        repeat (8) @(posedge clock);
        check_all();
        power_down_n <= 1'b1;
        repeat (8) @(posedge clock);
        check_all();
        print_verdict();
    end
endmodule : qds_dac_if_tb
`default_nettype wire
